/* bench/cefm_host_model.sv */
// Purpose: host side of the register port, issuing single reads and writes
// Assumes: the serial-bus engine has already turned bus frames into strobes
// Notes:   one request at a time; strobes last one clock
`timescale 1ns/1ps
`default_nettype none
module cefm_host_model
(
    // clock
    input wire logic clk_sys,
    // register port
    output logic [7:0] regAddr,
    output logic regWrite,
    output logic [7:0] regWrData,
    output logic regRead,
    input wire logic [7:0] regRdData
);
    // --------------------------------------------------------------
    // idle levels
    // --------------------------------------------------------------
    initial
    begin
        regAddr = 8'h00;
        regWrite = 1'b0;
        regWrData = 8'h00;
        regRead = 1'b0;
    end

    // --------------------------------------------------------------
    // bus cycles
    // --------------------------------------------------------------
    // one write; data is scrambled afterwards so stale values never help
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
        regWrData <= ~d;
        regAddr <= ~a;
    endtask

    // one read; data is taken once the read edge has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        regAddr <= ~a;
        #1;
        d = regRdData;
    endtask
endmodule // cefm_host_model
`default_nettype wire

/* bench/tb.sv */
// Purpose: self-checking bench of the charger event flag and mask bank
// Assumes: short interrupt pulse parameter for a quick run
// Notes:   inputs change on the rising edge by non-blocking assignment
`timescale 1ns/1ps
`default_nettype none
`include "cefm_regs.svh"
module tb;
    localparam int P = 3; // interrupt pulse length in cycles
    localparam int LIMIT = 20000; // cycle ceiling against hangs

    // --------------------------------------------------------------
    // signals
    // --------------------------------------------------------------
    logic clk_sys; // system clock
    logic rst_n; // synchronous reset
    logic regResetCmd; // register-reset command
    logic [7:0] regAddr;
    logic regWrite;
    logic [7:0] regWrData;
    logic regRead;
    logic [7:0] regRdData;
    logic [3:0] lvl; // protection condition levels
    logic [23:0] evt; // charger events, C B A
    logic intN; // interrupt output
    int miscompares; // mismatches seen
    int checked; // comparisons made
    int cycles; // cycle counter for the timeout
    logic [7:0] d; // last read data

    cefm_top #(.INT_PULSE_CYC(P)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .regResetCmd(regResetCmd), .regAddr(regAddr), .regWrite(regWrite),
        .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData),
        .inputAOvervoltLevel(lvl[0]), .sysShortLevel(lvl[1]), .sysOvervoltLevel(lvl[2]),
        .thermalShutdownLevel(lvl[3]), .chargerEvtA(evt[7:0]),
        .chargerEvtB(evt[15:8]), .chargerEvtC(evt[23:16]), .intN(intN));

    cefm_host_model host (.clk_sys(clk_sys), .regAddr(regAddr), .regWrite(regWrite),
        .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData));

    // --------------------------------------------------------------
    // clock, timeout and reporting
    // --------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // cut a hang short
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            miscompares = miscompares + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // compare one value
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked = checked + 1;
        if (seen !== exp)
        begin
            miscompares = miscompares + 1;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // measure the next interrupt pulse length, zero when none comes
    task automatic chk_pulse(input logic [7:0] exp);
        int n;
        int w;
        n = 0;
        w = 0;
        while (intN === 1'b1 && w < 4)
        begin
            @(posedge clk_sys);
            #1;
            w++;
        end
        while (intN === 1'b0 && n < P + 2)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check("pulse length", 8'(n), exp);
        repeat (2) @(posedge clk_sys);
    endtask

    // one-cycle event pulse, then judge the interrupt
    task automatic fire(input logic [23:0] v, input logic [7:0] exp);
        @(posedge clk_sys);
        evt <= v;
        @(posedge clk_sys);
        evt <= 24'h000000;
        #1;
        chk_pulse(exp);
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    // reset values, unmapped and read-only places
    task automatic t_defaults();
        check("intN idle", {7'h00, intN}, 8'h01);
        for (int a = 8'h26; a <= 8'h2b; a++)
        begin
            host.rd(8'(a), d);
            check("reset value", d, 8'h00);
        end
        host.wr(`CEFM_ADDR_FLAGS_B, 8'hff);
        host.rd(`CEFM_ADDR_FLAGS_B, d);
        check("flags b after write", d, 8'h00);
    endtask

    // masks read back with reserved bits zero, then the reset command
    task automatic t_masks();
        logic [7:0] wm [3];
        wm = '{8'hff, 8'hd7, 8'h7f};
        for (int r = 0; r < 3; r++)
        begin
            host.wr(8'(8'h28 + r), 8'hff);
            host.rd(8'(8'h28 + r), d);
            check("mask readback", d, wm[r]);
        end
        host.wr(`CEFM_ADDR_MASKS_A, 8'h5a);
        host.rd(`CEFM_ADDR_MASKS_A, d);
        check("mask a pattern", d, 8'h5a);
        // the reset command wins over a write in the same cycle
        fork
            host.wr(`CEFM_ADDR_MASKS_B, 8'hff);
            begin
                @(posedge clk_sys);
                regResetCmd <= 1'b1;
                @(posedge clk_sys);
                regResetCmd <= 1'b0;
            end
        join
        for (int r = 0; r < 3; r++)
        begin
            host.rd(8'(8'h28 + r), d);
            check("mask after reset cmd", d, 8'h00);
        end
    endtask

    // each protection condition sets its flag, sticky until gone and read
    task automatic t_flags();
        logic [7:0] fa [4];
        logic [7:0] fv [4];
        fa = '{8'h26, 8'h27, 8'h27, 8'h27};
        fv = '{8'h01, 8'h80, 8'h40, 8'h04};
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk_sys);
            lvl[i] <= 1'b1;
            @(posedge clk_sys);
            #1;
            chk_pulse(8'(P));
            host.rd(fa[i], d);
            check("flag set", d, fv[i]);
            host.rd(fa[i], d);
            check("flag sticky", d, fv[i]);
            @(posedge clk_sys);
            lvl[i] <= 1'b0;
            host.rd(fa[i], d);
            host.rd(fa[i], d);
            check("flag cleared", d, 8'h00);
        end
    endtask

    // every event bit against its own mask bit and its neighbours
    task automatic t_events();
        logic [7:0] wm [3];
        logic [7:0] m;
        wm = '{8'hff, 8'hd7, 8'h7f};
        for (int r = 0; r < 3; r++)
        begin
            for (int b = 0; b < 8; b++)
            begin
                m = 8'h01 << b;
                if ((wm[r] & m) == 8'h00)
                begin
                    fire(24'h000001 << (8 * r + b), 8'h00);
                end
                else
                begin
                    fire(24'h000001 << (8 * r + b), 8'(P));
                    host.wr(8'(8'h28 + r), m);
                    fire(24'h000001 << (8 * r + b), 8'h00);
                    host.wr(8'(8'h28 + r), wm[r] & ~m);
                    fire(24'h000001 << (8 * r + b), 8'(P));
                    host.wr(8'(8'h28 + r), 8'h00);
                end
            end
        end
        fire(24'h010480, 8'(P));
    endtask

    // an event during a pulse is kept and replayed once the pulse ends
    task automatic t_replay();
        @(posedge clk_sys);
        evt <= 24'h000002;
        @(posedge clk_sys);
        evt <= 24'h000004;
        @(posedge clk_sys);
        evt <= 24'h000000;
        repeat (P - 1) @(posedge clk_sys);
        #1;
        check("gap before replay", {7'h00, intN}, 8'h01);
        chk_pulse(8'(P));
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial
    begin
        miscompares = 0;
        checked = 0;
        cycles = 0;
        rst_n = 1'b0;
        regResetCmd = 1'b0;
        lvl = 4'h0;
        evt = 24'h000000;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_defaults();
        t_masks();
        t_flags();
        t_events();
        t_replay();
        end_of_test();
    end
endmodule // tb
`default_nettype wire

/* src/cefm_evt_if.sv */
// Purpose: carries unmasked events from the register file to the sequencer
// Assumes: one clock domain
// Notes:   one bit per event source
`timescale 1ns/1ps
`default_nettype none
interface cefm_evt_if #(parameter int W = 28);
    logic [W-1:0] evt; // unmasked one-cycle events
    modport src (output evt);
    modport dst (input evt);
endinterface
`default_nettype wire

/* src/cefm_flag_bank.sv */
// Purpose: sticky protection flags set on condition entry
// Assumes: levels synchronous to clk_sys
// Notes:   a read clears a flag only once its condition is gone
`timescale 1ns/1ps
`default_nettype none
module cefm_flag_bank
    import cefm_pkg::*;
#(
    parameter int W = 4
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // condition levels and read clears
    input wire logic [3:0] level,
    input wire logic [3:0] clearReq,
    // flag state
    output logic [3:0] flags,
    output logic [3:0] rise
);
`include "cefm_regs.svh"

    cefm_flag_state_type s; // registered state
    cefm_flag_state_type next_s; // next state

    // ------------------------------------------------------------------
    // entry detection and sticky flags
    // ------------------------------------------------------------------
    assign rise = level & ~s.prev;
    assign flags = s.flags;

    // a new entry wins over a clear in the same cycle
    always_comb
    begin
        next_s = s;
        next_s.prev = level;
        next_s.flags = (s.flags & ~(clearReq & ~level)) | rise;
    end

    // register the state
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            s <= '0;
        else
            s <= next_s;
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_flag_in_overvolt: assert property (rise[`CEFM_PROT_INPUT_A_OVERVOLT] |=>
        s.flags[0] ##1
        (s.flags[0] || $past(clearReq[0]))) else $error("input overvoltage flag lost");
    a_flag_short: assert property (rise[`CEFM_PROT_SYS_SHORT] |=> flags[1])
        else $error("system short flag not set");
    a_flag_sys_overvolt: assert property (rise[`CEFM_PROT_SYS_OVERVOLT] |=> flags[2])
        else $error("system overvoltage flag not set");
    a_flag_thermal: assert property (rise[`CEFM_PROT_THERMAL] |=> flags[3])
        else $error("thermal shutdown flag not set");
    a_flag_no_spurious: assert property ((s.flags == '0 && rise == '0) |=> flags == '0)
        else $error("flag set without entry");
    c_flag_cleared: cover property (flags[0] && clearReq[0] && !level[0] ##1 !flags[0]);

endmodule // cefm_flag_bank
`default_nettype wire

/* src/cefm_int_pulse.sv */
// Purpose: turns unmasked events into active-low interrupt pulses
// Assumes: events are one-cycle pulses
// Notes:   events during a pulse are remembered and replayed
`timescale 1ns/1ps
`default_nettype none
module cefm_int_pulse
    import cefm_pkg::*;
#(
    parameter int PULSE_CYC = 10
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // unmasked events
    cefm_evt_if.dst evtIf,
    // interrupt output, low during a pulse
    output var logic intN
);

    cefm_int_pulse_type s; // registered state
    cefm_int_pulse_type next_s; // next state
    logic anyEvt; // some unmasked event this cycle

    assign anyEvt = |evtIf.evt;
    assign intN = s.intN;

    // ------------------------------------------------------------------
    // pulse sequencer
    // ------------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        case (s.state)
            // start a pulse on a new or remembered event
            CEFM_IDLE:
            begin
                if (anyEvt || s.pend)
                begin
                    next_s.state = CEFM_PULSE;
                    next_s.cnt = 16'(PULSE_CYC - 1);
                    next_s.pend = 1'b0;
                    next_s.intN = 1'b0;
                end
            end
            // hold low, remember later events
            CEFM_PULSE:
            begin
                if (anyEvt)
                    next_s.pend = 1'b1;
                if (s.cnt == 16'h0000)
                begin
                    next_s.state = CEFM_IDLE;
                    next_s.intN = 1'b1;
                end
                else
                    next_s.cnt = s.cnt - 16'h0001;
            end
            default:
            begin
                next_s.state = CEFM_IDLE;
                next_s.intN = 1'b1;
            end
        endcase
    end

    // register the state
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            s.state <= CEFM_IDLE;
            s.cnt <= 16'h0000;
            s.pend <= 1'b0;
            s.intN <= 1'b1;
        end
        else
            s <= next_s;
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_pulse_start: assert property ((s.state == CEFM_IDLE && anyEvt) |=> !intN)
        else $error("event did not start a pulse");
    a_pulse_end: assert property ((s.state == CEFM_PULSE && s.cnt == 16'h0000) |=> intN)
        else $error("pulse did not end");
    a_pulse_hold: assert property ((s.state == CEFM_PULSE && s.cnt != 16'h0000) |=> !intN)
        else $error("pulse ended early");
    a_event_kept: assert property ((s.state == CEFM_PULSE && anyEvt) |=> s.pend)
        else $error("event during pulse lost");
    // a remembered event starts its own pulse once the sequencer is idle
    a_replay_start: assert property ((s.state == CEFM_IDLE && s.pend) |=> !intN)
        else $error("remembered event not replayed");
    a_quiet_idle: assert property ((s.state == CEFM_IDLE && !s.pend && !anyEvt) |=> intN)
        else $error("pulse without event");
    c_pulse_seen: cover property (s.state == CEFM_IDLE && anyEvt ##1 !intN);
    c_replay_seen: cover property (s.state == CEFM_IDLE && s.pend);

endmodule // cefm_int_pulse
`default_nettype wire

/* src/cefm_pkg.sv */
// Purpose: shared types of the charger event flag and mask bank
// Assumes: nothing
// Notes:   offsets and counts live in cefm_regs.svh
package cefm_pkg;

    // ------------------------------------------------------------------
    // interrupt pulse sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        CEFM_IDLE = 1'b0,
        CEFM_PULSE = 1'b1
    } cefm_int_state_type;

    // flag bank state
    typedef struct packed {
        logic [3:0] prev;
        logic [3:0] flags;
    } cefm_flag_state_type;

    // interrupt sequencer state
    typedef struct packed {
        cefm_int_state_type state;
        logic [15:0] cnt;
        logic pend;
        logic intN;
    } cefm_int_pulse_type;

    // register file state
    typedef struct packed {
        logic [7:0] masksA;
        logic [7:0] masksB;
        logic [7:0] masksC;
        logic [7:0] rdData;
    } cefm_regs_type;

endpackage

/* src/cefm_regs.svh */
// Purpose: register offsets, field layout, reset values and timing counts
//          of the charger event flag and mask bank
// Assumes: 100 MHz system clock
// Notes:   definitions only
`ifndef CEFM_REGS_SVH
`define CEFM_REGS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define CEFM_ADDR_FLAGS_A 8'h26
`define CEFM_ADDR_FLAGS_B 8'h27
`define CEFM_ADDR_MASKS_A 8'h28
`define CEFM_ADDR_MASKS_B 8'h29
`define CEFM_ADDR_MASKS_C 8'h2a

// ----------------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------------
`define CEFM_BIT_INPUT_A_OVERVOLT 0
`define CEFM_BIT_SYS_SHORT 7
`define CEFM_BIT_SYS_OVERVOLT 6
`define CEFM_BIT_THERMAL_SHUTDOWN 2
`define CEFM_FLAGS_B_USED 8'hc4
`define CEFM_MASKS_A_WRITABLE 8'hff
`define CEFM_MASKS_B_WRITABLE 8'hd7
`define CEFM_MASKS_C_WRITABLE 8'h7f
`define CEFM_MASK_RESET 8'h00
// protection vector positions
`define CEFM_PROT_INPUT_A_OVERVOLT 0
`define CEFM_PROT_SYS_SHORT 1
`define CEFM_PROT_SYS_OVERVOLT 2
`define CEFM_PROT_THERMAL 3
`define CEFM_PROT_COUNT 4

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CEFM_CLK_PERIOD_NS 10
`define CEFM_INT_PULSE_NS 100
`define CEFM_INT_PULSE_CYC ((`CEFM_INT_PULSE_NS + `CEFM_CLK_PERIOD_NS - 1) / `CEFM_CLK_PERIOD_NS)

`endif

/* src/cefm_top.sv */
// Purpose: charger event flag and interrupt mask register bank
// Assumes: register port is the parallel side of the serial-bus engine;
//          event and condition inputs synchronous to clk_sys
// Notes:   read data is valid on the cycle after regRead
`timescale 1ns/1ps
`default_nettype none
module cefm_top
    import cefm_pkg::*;
#(
    parameter int INT_PULSE_CYC = 10
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic regResetCmd,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWrData,
    input wire logic regRead,
    output logic [7:0] regRdData,
    // protection condition levels
    input wire logic inputAOvervoltLevel,
    input wire logic sysShortLevel,
    input wire logic sysOvervoltLevel,
    input wire logic thermalShutdownLevel,
    // charger events, one-cycle pulses, laid out as the mask bits
    input wire logic [7:0] chargerEvtA,
    input wire logic [7:0] chargerEvtB,
    input wire logic [7:0] chargerEvtC,
    // interrupt, low during a pulse
    output logic intN
);
`include "cefm_regs.svh"

    cefm_regs_type s; // registered state
    cefm_regs_type next_s; // next state
    logic [3:0] protLevel; // condition levels
    logic [3:0] clearReq; // read clears
    logic [3:0] flags; // sticky flags
    logic [3:0] rise; // condition entries
    logic [7:0] flagsA; // first flag register image
    logic [7:0] flagsB; // second flag register image

    cefm_evt_if #(.W(28)) evtIf ();

    // ------------------------------------------------------------------
    // protection flags
    // ------------------------------------------------------------------
    assign protLevel = {thermalShutdownLevel, sysOvervoltLevel, sysShortLevel,
        inputAOvervoltLevel};

    // reading a flag register asks to clear its flags
    assign clearReq[0] = regRead && (regAddr == `CEFM_ADDR_FLAGS_A);
    assign clearReq[3:1] = {3{regRead && (regAddr == `CEFM_ADDR_FLAGS_B)}};

    cefm_flag_bank #(.W(4)) flagBank (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .level(protLevel),
        .clearReq(clearReq),
        .flags(flags),
        .rise(rise)
    );

    // register images, unused bits zero
    always_comb
    begin
        flagsA = 8'h00;
        flagsB = 8'h00;
        flagsA[`CEFM_BIT_INPUT_A_OVERVOLT] = flags[`CEFM_PROT_INPUT_A_OVERVOLT];
        flagsB[`CEFM_BIT_SYS_SHORT] = flags[`CEFM_PROT_SYS_SHORT];
        flagsB[`CEFM_BIT_SYS_OVERVOLT] = flags[`CEFM_PROT_SYS_OVERVOLT];
        flagsB[`CEFM_BIT_THERMAL_SHUTDOWN] = flags[`CEFM_PROT_THERMAL];
    end

    // ------------------------------------------------------------------
    // event gating
    // ------------------------------------------------------------------
    // a set mask bit blocks its event; protection entries always pass
    // reserved event bits never reach the sequencer
    assign evtIf.evt = {rise,
        chargerEvtC & `CEFM_MASKS_C_WRITABLE & ~s.masksC,
        chargerEvtB & `CEFM_MASKS_B_WRITABLE & ~s.masksB,
        chargerEvtA & `CEFM_MASKS_A_WRITABLE & ~s.masksA};

    cefm_int_pulse #(.PULSE_CYC(INT_PULSE_CYC)) intPulse (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .evtIf(evtIf),
        .intN(intN)
    );

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    assign regRdData = s.rdData;

    always_comb
    begin
        next_s = s;
        // writes touch only writable bits
        if (regResetCmd)
        begin
            next_s.masksA = `CEFM_MASK_RESET;
            next_s.masksB = `CEFM_MASK_RESET;
            next_s.masksC = `CEFM_MASK_RESET;
        end
        else if (regWrite && regAddr == `CEFM_ADDR_MASKS_A)
            next_s.masksA = regWrData & `CEFM_MASKS_A_WRITABLE;
        else if (regWrite && regAddr == `CEFM_ADDR_MASKS_B)
            next_s.masksB = regWrData & `CEFM_MASKS_B_WRITABLE;
        else if (regWrite && regAddr == `CEFM_ADDR_MASKS_C)
            next_s.masksC = regWrData & `CEFM_MASKS_C_WRITABLE;
        // read data, unmapped offsets read zero
        if (!regRead)
            next_s.rdData = s.rdData;
        else if (regAddr == `CEFM_ADDR_FLAGS_A)
            next_s.rdData = flagsA;
        else if (regAddr == `CEFM_ADDR_FLAGS_B)
            next_s.rdData = flagsB;
        else if (regAddr == `CEFM_ADDR_MASKS_A)
            next_s.rdData = s.masksA;
        else if (regAddr == `CEFM_ADDR_MASKS_B)
            next_s.rdData = s.masksB;
        else if (regAddr == `CEFM_ADDR_MASKS_C)
            next_s.rdData = s.masksC;
        else
            next_s.rdData = 8'h00;
    end

    // register the state
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            s <= '0;
        else
            s <= next_s;
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_flag_b_resv: assert property ((regRead && regAddr == `CEFM_ADDR_FLAGS_B) |=>
        (regRdData & ~`CEFM_FLAGS_B_USED) == 8'h00) else $error("reserved flag bit set");
    a_mask_cmd_reset: assert property (regResetCmd |=>
        (s.masksA == 8'h00 && s.masksB == 8'h00 && s.masksC == 8'h00))
        else $error("masks not cleared by reset command");
    a_mask_a_write: assert property (regWrite && !regResetCmd &&
        regAddr == `CEFM_ADDR_MASKS_A |=> s.masksA == $past(regWrData))
        else $error("mask A write lost");
    a_mask_readback: assert property ((regRead && regAddr == `CEFM_ADDR_MASKS_B)
        |=> regRdData == $past(s.masksB)) else $error("mask B read wrong");
    a_mask_b_resv: assert property ((s.masksB & ~`CEFM_MASKS_B_WRITABLE) == 8'h00)
        else $error("reserved mask B bit set");
    a_mask_c_resv: assert property (s.masksC[7] == 1'b0)
        else $error("reserved mask C bit set");
    a_gate_current: assert property ((chargerEvtA[7] && s.masksA[7]) |-> !evtIf.evt[7])
        else $error("masked current limit event passed");
    a_gate_watchdog: assert property ((chargerEvtA[5] && !s.masksA[5]) |-> evtIf.evt[5])
        else $error("unmasked watchdog event blocked");
    a_gate_thermal_reg: assert property ((chargerEvtB[2] && s.masksB[2]) |-> !evtIf.evt[10])
        else $error("masked thermal regulation event passed");
    a_unknown_zero: assert property ((regRead && regAddr == 8'h00) |=> regRdData == 8'h00)
        else $error("unmapped offset read nonzero");
    c_mask_written: cover property (regWrite && regAddr == `CEFM_ADDR_MASKS_C);
    c_flag_read: cover property (regRead && regAddr == `CEFM_ADDR_FLAGS_B && flags[1]);

endmodule // cefm_top
`default_nettype wire
